// *** core/ctt_core.sv ***
/*
 Execution core for the test family, the stack/index/accumulator transfers
 and the indexed, stack and move addressing modes.
 Assumes a synchronous memory that answers a read on the next clock in rdata_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ctt_map.svh"

// Summary of operation
// [RULE_01] Test subtracts zero from A, X or memory, clears V, sets N and Z, keeps H, I and C.
// [RULE_02] Test opcodes 3D, 4D, 5D, 6D, 7D and 9E6D take 3, 1, 1, 3, 2 and 4 cycles.
// [RULE_03] Opcode 95 loads H:X with SP plus one in 2 cycles and keeps all flags.
// [RULE_04] Opcode 9F copies X into A in 1 cycle and keeps all flags.
// [RULE_05] Opcode 94 loads SP with H:X minus one in 2 cycles and keeps all flags.
// [RULE_06] Stack modes address SP plus an unsigned 8-bit or high-then-low 16-bit offset.
// [RULE_07] The 16-bit indexed mode adds a high-then-low offset to H:X.
// [RULE_08] Post-increment indexed mode addresses H:X and then increments H:X.
// [RULE_09] The 8-bit offset post-increment mode adds a byte to H:X, then increments H:X.
// [RULE_10] Indexed-to-direct move reads at H:X, writes a direct address, then increments H:X.
// [RULE_11] Immediate-to-direct move stores an immediate byte at a direct address.
// [RULE_12] A leading 9E byte selects the stack-relative variant and adds one byte.
module ctt_core (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [7:0]       rdata_i,
  output ctt_pkg::ctt_mem_req_t mem_o,
  output ctt_pkg::ctt_regs_t    regs_o,
  output logic                  instr_done_o,
  output logic                  illegal_op_o
);
  import ctt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state
  ctt_state_t  state;
  logic [7:0]  acc;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0]  condition_code_reg;
  logic [7:0]  opcode;
  logic        prefix;
  logic [15:0] ea;
  logic [7:0]  opnd_hi;
  logic [7:0]  mov_data;
  logic [3:0]  cyc_left;
  logic        rd_pending;
  logic        wr_pending;
  logic [15:0] addr;
  logic        done;
  logic        illegal;

  // Opcode classes
  logic is_tst_mem;
  logic is_sp1;
  logic is_sp2;
  logic is_ix2;
  logic is_cbeq_ixp;
  logic is_cbeq_ix1p;
  logic two_opnd;
  logic one_opnd;

  always_comb begin
    is_sp1       = prefix && (opcode == `CTT_OP_TST_IX1);                    // [RULE_12]
    is_sp2       = prefix && (opcode == `CTT_OP_LDA_SP2);                    // [RULE_12]
    is_ix2       = !prefix && (opcode == `CTT_OP_LDA_IX2);
    is_cbeq_ixp  = !prefix && (opcode == `CTT_OP_CBEQ_IXP);
    is_cbeq_ix1p = !prefix && (opcode == `CTT_OP_CBEQ_IX1P);
    is_tst_mem   = (opcode == `CTT_OP_TST_DIR) || (opcode == `CTT_OP_TST_IX1) ||
                   (opcode == `CTT_OP_TST_IX);
    two_opnd     = is_sp2 || is_ix2 || (!prefix && opcode == `CTT_OP_MOV_IMD);
    one_opnd     = is_sp1 || (!prefix && (opcode == `CTT_OP_TST_DIR ||
                   opcode == `CTT_OP_TST_IX1 || opcode == `CTT_OP_MOV_IXD ||
                   is_cbeq_ix1p));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state      <= CTT_FETCH;
      opcode     <= 8'h00;
      prefix     <= 1'b0;
      ea         <= 16'h0000;
      opnd_hi    <= 8'h00;
      mov_data   <= 8'h00;
      cyc_left   <= 4'h0;
      rd_pending <= 1'b0;
      wr_pending <= 1'b0;
      done       <= 1'b0;
      illegal    <= 1'b0;
    end else begin
      done    <= 1'b0;
      illegal <= 1'b0;
      case (state)
        CTT_FETCH: begin
          if (rd_pending) begin
            rd_pending <= 1'b0;
            if (rdata_i == `CTT_OP_PREFIX && !prefix) begin
              prefix <= 1'b1;                                                  // [RULE_12]
            end else begin
              opcode <= rdata_i;
              state  <= CTT_OPND1;
            end
          end else begin
            rd_pending <= 1'b1;
          end
        end
        CTT_OPND1: begin
          if (!prefix && (opcode == `CTT_OP_TST_A || opcode == `CTT_OP_TST_X ||
              opcode == `CTT_OP_TXA)) begin
            cyc_left <= `CTT_CYC_TST_INH;                                      // [RULE_02]
            state    <= CTT_WAIT;
          end else if (!prefix && (opcode == `CTT_OP_TSX || opcode == `CTT_OP_TXS)) begin
            cyc_left <= `CTT_CYC_TSX;                                          // [RULE_02]
            state    <= CTT_WAIT;
          end else if (!prefix && (opcode == `CTT_OP_TST_IX || is_cbeq_ixp)) begin
            ea       <= hx;                                                    // [RULE_08]
            cyc_left <= `CTT_CYC_TST_IX;
            state    <= CTT_READ;
          end else if (one_opnd || two_opnd) begin
            if (rd_pending) begin
              rd_pending <= 1'b0;
              opnd_hi    <= rdata_i;
              if (two_opnd) begin
                state <= CTT_OPND2;
              end else if (is_sp1) begin
                ea       <= sp + {8'h00, rdata_i};                             // [RULE_06]
                cyc_left <= `CTT_CYC_TST_SP1;
                state    <= CTT_READ;
              end else if (opcode == `CTT_OP_TST_IX1 || is_cbeq_ix1p) begin
                ea       <= hx + {8'h00, rdata_i};                             // [RULE_09]
                cyc_left <= `CTT_CYC_TST_IX1;
                state    <= CTT_READ;
              end else if (opcode == `CTT_OP_MOV_IXD) begin
                ea       <= hx;                                                // [RULE_10]
                cyc_left <= `CTT_CYC_TST_IX1;
                state    <= CTT_READ;
              end else begin
                ea       <= {8'h00, rdata_i};
                cyc_left <= `CTT_CYC_TST_DIR;
                state    <= CTT_READ;
              end
            end else begin
              rd_pending <= 1'b1;
            end
          end else begin
            illegal <= 1'b1;
            done    <= 1'b1;
            prefix  <= 1'b0;
            state   <= CTT_FETCH;
          end
        end
        CTT_OPND2: begin
          if (rd_pending) begin
            rd_pending <= 1'b0;
            cyc_left   <= `CTT_CYC_TST_SP1;
            if (is_sp2) begin
              ea    <= sp + {opnd_hi, rdata_i};                                // [RULE_06]
              state <= CTT_READ;
            end else if (is_ix2) begin
              ea    <= hx + {opnd_hi, rdata_i};                                // [RULE_07]
              state <= CTT_READ;
            end else begin
              mov_data <= opnd_hi;                                             // [RULE_11]
              ea       <= {8'h00, rdata_i};
              state    <= CTT_WRITE;
            end
          end else begin
            rd_pending <= 1'b1;
          end
        end
        CTT_READ: begin
          if (rd_pending) begin
            rd_pending <= 1'b0;
            mov_data   <= rdata_i;
            if (!prefix && opcode == `CTT_OP_MOV_IXD) begin
              ea    <= {8'h00, opnd_hi};                                       // [RULE_10]
              state <= CTT_WRITE;
            end else begin
              state <= CTT_WAIT;
            end
          end else begin
            rd_pending <= 1'b1;
          end
        end
        CTT_WRITE: begin
          if (wr_pending) begin
            wr_pending <= 1'b0;
            state      <= CTT_WAIT;
          end else begin
            wr_pending <= 1'b1;
          end
        end
        CTT_WAIT: begin
          if (cyc_left > 4'h1) begin
            cyc_left <= cyc_left - 4'h1;                                       // [RULE_02]
          end else begin
            done   <= 1'b1;
            prefix <= 1'b0;
            state  <= CTT_FETCH;
          end
        end
        default: begin
          state <= CTT_FETCH;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter: one step per byte fetched from the stream
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pc <= 16'h0000;
    end else if (rd_pending && (state == CTT_FETCH || state == CTT_OPND1 ||
                 state == CTT_OPND2)) begin
      pc <= pc + 16'h0001;                                                     // [RULE_12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Final cycle of the timed wait
  logic last_wait;
  assign last_wait = (state == CTT_WAIT) && (cyc_left <= 4'h1);                // [RULE_02]

  ////////////////////////////////////////////////////////////////////////////
  // Register file and flags at completion
  logic [7:0] tst_val;
  always_comb begin
    if (!prefix && opcode == `CTT_OP_TST_A) begin
      tst_val = acc - 8'h00;                                                   // [RULE_01]
    end else if (!prefix && opcode == `CTT_OP_TST_X) begin
      tst_val = hx[7:0] - 8'h00;                                               // [RULE_01]
    end else begin
      tst_val = mov_data - 8'h00;                                              // [RULE_01]
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acc <= 8'h00;
      hx  <= 16'h0000;
      sp  <= `CTT_SP_RESET;
      condition_code_reg <= `CTT_CCR_RESET;
    end else if (last_wait) begin
      if (!prefix && opcode == `CTT_OP_TSX) begin
        hx <= sp + 16'h0001;                                                   // [RULE_03]
      end else if (!prefix && opcode == `CTT_OP_TXA) begin
        acc <= hx[7:0];                                                        // [RULE_04]
      end else if (!prefix && opcode == `CTT_OP_TXS) begin
        sp <= hx - 16'h0001;                                                   // [RULE_05]
      end else if (!prefix && (opcode == `CTT_OP_MOV_IXD || is_cbeq_ixp ||
                   is_cbeq_ix1p)) begin
        hx <= hx + 16'h0001;                                                   // [RULE_08] [RULE_09] [RULE_10]
      end
      if (is_tst_mem || opcode == `CTT_OP_TST_A || opcode == `CTT_OP_TST_X) begin
        condition_code_reg[`CTT_CCR_V] <= 1'b0;                                               // [RULE_01]
        condition_code_reg[`CTT_CCR_N] <= tst_val[7];                                         // [RULE_01]
        condition_code_reg[`CTT_CCR_Z] <= (tst_val == 8'h00);                                 // [RULE_01]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory request and outputs
  always_comb begin
    if (state == CTT_READ || state == CTT_WRITE) begin
      addr = ea;
    end else begin
      addr = pc;
    end
    mem_o.addr  = addr;
    mem_o.rd    = (state != CTT_WRITE) && (state != CTT_WAIT) && !rd_pending &&
                  !(state == CTT_OPND1 && !(one_opnd || two_opnd));
    mem_o.wr    = (state == CTT_WRITE) && !wr_pending;
    mem_o.wdata = mov_data;
    regs_o.acc  = acc;
    regs_o.hx   = hx;
    regs_o.sp   = sp;
    regs_o.pc   = pc;
    regs_o.condition_code_reg  = condition_code_reg;
  end

  assign instr_done_o = done;
  assign illegal_op_o = illegal;

endmodule : ctt_core
`default_nettype wire

// *** inc/ctt_map.svh ***
/*
 Constants for the test and transfer execution core: opcodes, flag positions,
 reset values and cycle counts. Assumes inclusion by bare name.
*/
`ifndef CTT_MAP_SVH
`define CTT_MAP_SVH
`define CTT_OP_TST_DIR   8'h3D
`define CTT_OP_TST_A     8'h4D
`define CTT_OP_TST_X     8'h5D
`define CTT_OP_TST_IX1   8'h6D
`define CTT_OP_TST_IX    8'h7D
`define CTT_OP_PREFIX    8'h9E
`define CTT_OP_TSX       8'h95
`define CTT_OP_TXA       8'h9F
`define CTT_OP_TXS       8'h94
`define CTT_OP_MOV_IXD   8'h7E
`define CTT_OP_MOV_IMD   8'h6E
`define CTT_OP_LDA_SP2   8'hD6
`define CTT_OP_LDA_IX2   8'hD6
`define CTT_OP_CBEQ_IXP  8'h71
`define CTT_OP_CBEQ_IX1P 8'h61
`define CTT_CCR_V        7
`define CTT_CCR_H        4
`define CTT_CCR_I        3
`define CTT_CCR_N        2
`define CTT_CCR_Z        1
`define CTT_CCR_C        0
`define CTT_CCR_RESET    8'h68
`define CTT_SP_RESET     16'h00FF
`define CTT_CYC_TST_DIR  4'h3
`define CTT_CYC_TST_INH  4'h1
`define CTT_CYC_TST_IX1  4'h3
`define CTT_CYC_TST_IX   4'h2
`define CTT_CYC_TST_SP1  4'h4
`define CTT_CYC_TSX      4'h2
`define CTT_CYC_TXA      4'h1
`define CTT_CYC_TXS      4'h2
`endif

// *** inc/ctt_pkg.sv ***
/*
 Types for the test and transfer execution core.
 Assumes the map header sits on the include path.
*/
package ctt_pkg;
  typedef enum logic [2:0] {
    CTT_FETCH = 3'b000,
    CTT_OPND1 = 3'b001,
    CTT_OPND2 = 3'b010,
    CTT_READ  = 3'b011,
    CTT_WRITE = 3'b100,
    CTT_WAIT  = 3'b101
  } ctt_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } ctt_mem_req_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  condition_code_reg;
  } ctt_regs_t;
endpackage : ctt_pkg

// *** sim/ctt_core_asserts.sv ***
/*
 Port checker for ctt_core.
 Assumes binding to every ctt_core instance.
*/
`timescale 1ns/1ps
`default_nettype none
module ctt_core_chk (
  input wire logic                  clock_i,
  input wire logic                  rst_n_i,
  input wire logic [7:0]            rdata_i,
  input wire ctt_pkg::ctt_mem_req_t mem_o,
  input wire ctt_pkg::ctt_regs_t    regs_o,
  input wire logic                  instr_done_o,
  input wire logic                  illegal_op_o
);
  import ctt_pkg::*;
  logic       fetch;
  logic       op_rd;
  logic [7:0] op;
  // First byte of the running instruction (the 9E prefix for prefixed ones)
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) fetch <= 1'b1;
    else if (mem_o.rd) fetch <= 1'b0;
    else if (instr_done_o) fetch <= 1'b1;
  end
  always_ff @(posedge clock_i) op_rd <= rst_n_i && mem_o.rd && (fetch || instr_done_o);
  always_ff @(posedge clock_i) if (op_rd) op <= rdata_i;
  ////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_tsx_value: assert property (instr_done_o && op == 8'h95 |->
    regs_o.hx == regs_o.sp + 16'h0001) else $error("stack_to_index_op value");
  a_txs_value: assert property (instr_done_o && op == 8'h94 |->
    regs_o.sp == regs_o.hx - 16'h0001) else $error("index_to_stack_op value");
  a_txa_value: assert property (instr_done_o && op == 8'h9F |->
    regs_o.acc == regs_o.hx[7:0]) else $error("index_to_accumulator_op value");
  a_test_accumulator_op_flags: assert property (instr_done_o && op == 8'h4D |-> !regs_o.condition_code_reg[7] &&
    regs_o.condition_code_reg[2] == regs_o.acc[7] && regs_o.condition_code_reg[1] == (regs_o.acc == 8'h00))
    else $error("test_accumulator_op flags");
  a_test_index_low_op_flags: assert property (instr_done_o && op == 8'h5D |-> !regs_o.condition_code_reg[7] &&
    regs_o.condition_code_reg[2] == regs_o.hx[7] && regs_o.condition_code_reg[1] == (regs_o.hx[7:0] == 8'h00))
    else $error("test_index_low_op flags");
  a_hic_kept: assert property ($stable({regs_o.condition_code_reg[4], regs_o.condition_code_reg[3], regs_o.condition_code_reg[0]}))
    else $error("H, I or C changed");
  a_done_pulse: assert property (instr_done_o |=> !instr_done_o)
    else $error("done longer than one cycle");
  a_read_ends: assert property (mem_o.rd |-> ##[0:16] instr_done_o)
    else $error("instruction did not end");
  a_illegal_done: assert property (illegal_op_o |-> instr_done_o)
    else $error("illegal without done");
  a_write_pulse: assert property (mem_o.wr |=> !mem_o.wr)
    else $error("write longer than one cycle");
  c_tsx: cover property (instr_done_o && op == 8'h95);
  c_test_accumulator_op: cover property (instr_done_o && op == 8'h4D);
  c_illegal: cover property (illegal_op_o);
endmodule : ctt_core_chk
bind ctt_core ctt_core_chk chk_u (.clock_i, .rst_n_i, .rdata_i, .mem_o, .regs_o,
  .instr_done_o, .illegal_op_o);
`default_nettype wire

// *** sim/ctt_mem_model.sv ***
/*
 Program memory model: answers a read on the next clock.
 Assumes the bench preloads mem.
*/
`timescale 1ns/1ps
`default_nettype none
module ctt_mem_model (
  input  wire logic             clock_i,
  input  wire ctt_pkg::ctt_mem_req_t req_i,
  output logic [7:0]            rdata_o
);
  import ctt_pkg::*;
  logic [7:0] mem [0:65535];
  initial rdata_o = 8'h00;
  // Data stands one cycle, then the bus changes
  always @(posedge clock_i) begin
    if (req_i.rd) rdata_o <= mem[req_i.addr];
    else rdata_o <= ~rdata_o;
    if (req_i.wr) mem[req_i.addr] <= req_i.wdata;
  end
endmodule : ctt_mem_model
`default_nettype wire

// *** sim/tb.sv ***
/*
 Bench: runs a short program and checks registers at each instruction end but the last, where it checks the illegal flag and both move results.
 Assumes ctt_mem_model as program memory.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctt_pkg::*;
  logic         clock_i;
  logic         rst_n_i;
  logic [7:0]   rdata;
  ctt_mem_req_t mem;
  ctt_regs_t    regs;
  logic         done;
  logic         illegal;
  int           n_mismatch;
  int           compares;
  logic [7:0]   prog [0:30] = '{8'h95, 8'h9F, 8'h4D, 8'h3D, 8'h80, 8'h5D, 8'h9E, 8'h6D,
    8'h01, 8'h6D, 8'h02, 8'h7D, 8'h6E, 8'h55, 8'h90, 8'h7E, 8'h91, 8'h71, 8'h61, 8'h00,
    8'hD6, 8'h01, 8'h00, 8'h9E, 8'hD6, 8'h01, 8'h01, 8'h4D, 8'h94, 8'h9E, 8'h95};
  logic [15:0]  last_rd;
  always @(posedge clock_i) if (mem.rd) last_rd <= mem.addr;
  ctt_core dut_u (.clock_i, .rst_n_i, .rdata_i(rdata), .mem_o(mem), .regs_o(regs),
    .instr_done_o(done), .illegal_op_o(illegal));
  ctt_mem_model mem_u (.clock_i, .req_i(mem), .rdata_o(rdata));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic wait_done;
    int i = 0;
    do begin
      @(posedge clock_i);
      #1;
      i++;
    end while (done !== 1'b1 && i < 60);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("ERROR done expected 1 seen %b", done);
      results();
    end
  endtask : wait_done
  task automatic step(input string nm, input logic [7:0] a, input logic [15:0] h, s, p,
                      input logic [7:0] c, input bit kc = 1'b1);
    wait_done();
    chk({nm, " acc"}, {8'h00, a}, {8'h00, regs.acc});
    chk({nm, " hx"}, h, regs.hx);
    chk({nm, " sp"}, s, regs.sp);
    chk({nm, " pc"}, p, regs.pc);
    if (kc) chk({nm, " ccr"}, {8'h00, c}, {8'h00, regs.condition_code_reg});
    chk({nm, " illegal"}, 16'h0000, {15'h0000, illegal});
    $display("test %s done", nm);
  endtask : step
  ////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    n_mismatch = 0;
    compares = 0;
    for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'h00;
    for (int i = 0; i < 31; i++) mem_u.mem[i] = prog[i];
    mem_u.mem[16'h0080] = 8'hF0;
    mem_u.mem[16'h0100] = 8'h7F;
    mem_u.mem[16'h0102] = 8'h80;
    mem_u.mem[16'h0200] = 8'hA5;
    mem_u.mem[16'h0203] = 8'h3C;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    step("tsx", 8'h00, 16'h0100, 16'h00FF, 16'h0001, 8'h68);
    step("txa", 8'h00, 16'h0100, 16'h00FF, 16'h0002, 8'h68);
    step("test_accumulator_op", 8'h00, 16'h0100, 16'h00FF, 16'h0003, 8'h6A);
    step("tstdir", 8'h00, 16'h0100, 16'h00FF, 16'h0005, 8'h6C);
    step("test_index_low_op", 8'h00, 16'h0100, 16'h00FF, 16'h0006, 8'h6A);
    step("tstsp1", 8'h00, 16'h0100, 16'h00FF, 16'h0009, 8'h68);
    step("tstix1", 8'h00, 16'h0100, 16'h00FF, 16'h000B, 8'h6C);
    step("tstix", 8'h00, 16'h0100, 16'h00FF, 16'h000C, 8'h68);
    step("movimd", 8'h00, 16'h0100, 16'h00FF, 16'h000F, 8'h00, 1'b0);
    step("movixd", 8'h00, 16'h0101, 16'h00FF, 16'h0011, 8'h00, 1'b0);
    step("ixpost", 8'h00, 16'h0102, 16'h00FF, 16'h0012, 8'h00, 1'b0);
    step("ix1post", 8'h00, 16'h0103, 16'h00FF, 16'h0014, 8'h00, 1'b0);
    step("ix2", 8'h00, 16'h0103, 16'h00FF, 16'h0017, 8'h00, 1'b0);
    chk("ix2 addr", 16'h0203, last_rd);
    step("sp2", 8'h00, 16'h0103, 16'h00FF, 16'h001B, 8'h00, 1'b0);
    chk("sp2 addr", 16'h0200, last_rd);
    step("tstzero", 8'h00, 16'h0103, 16'h00FF, 16'h001C, 8'h6A);
    step("txs", 8'h00, 16'h0103, 16'h0102, 16'h001D, 8'h6A);
    wait_done();
    chk("prefix illegal", 16'h0001, {15'h0000, illegal});
    chk("mov imm", 16'h0055, {8'h00, mem_u.mem[16'h0090]});
    chk("mov ixd", 16'h007F, {8'h00, mem_u.mem[16'h0091]});
    results();
  end
endmodule : tb
`default_nettype wire
